// >>> hw/afl_pkg.sv
/*
  Shared constants and types for the ALU status flag block.
  Assumes a single 50 MHz core clock and an APB register port.
*/
package afl_pkg;

  // Flag bit positions inside the flag register
  localparam int FLG_N = 4;
  localparam int FLG_OV = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C = 0;
  localparam int FLG_W = 5;

  // APB byte addresses
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;

  // Reset values
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;

  // Operation codes from the execution pipeline
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,   // a + b
    OP_SUB = 4'h1,   // a - b, by a + ~b + 1
    OP_AND = 4'h2,
    OP_IOR = 4'h3,
    OP_XOR = 4'h4,
    OP_CLR = 4'h5,   // clear_file_instr
    OP_BCLR = 4'h6,  // bit_clear_instr, bit index in b[2:0]
    OP_BSET = 4'h7,  // bit_set_instr, bit index in b[2:0]
    OP_SWAP = 4'h8,  // nibble_swap_instr
    OP_MOVE = 4'h9,  // file_to_file / accumulator_to_file moves
    OP_ROTL = 4'ha,  // rotate_left_instr through carry
    OP_ROTR = 4'hb   // rotate_right_instr through carry
  } afl_op_t;

  // One ALU request
  typedef struct packed {
    afl_op_t op;
    logic [7:0] a;          // File operand or literal
    logic [7:0] b;          // Accumulator or bit index
    logic dest_flags;       // Destination is the flag register
  } afl_req_t;

  // ALU outcome
  typedef struct packed {
    logic [7:0] res;
    logic [4:0] flg;
    logic [4:0] upd;        // Flags this operation drives
  } afl_alu_t;

  // Whole block state
  typedef struct packed {
    logic [4:0] flags;
    logic [7:0] result;
    logic rvalid;
  } afl_state_t;

endpackage

// >>> hw/afl_status_flags.sv
/*
  ALU status flag logic: arithmetic, logic and rotate evaluation,
  the five-bit flag register, and an APB slave for software access.
  Assumes requests are synchronous to clk_in and one per cycle at most.
*/
`timescale 1ns/100ps
module afl_status_flags (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Execution pipeline request
  input wire logic op_valid_in,
  input wire afl_pkg::afl_req_t op_in,
  // Execution pipeline answer
  output logic [7:0] result_out,
  output logic result_valid_out,
  output logic [7:0] flags_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  afl_pkg::afl_state_t st_q;
  afl_pkg::afl_state_t st_d;
  afl_pkg::afl_alu_t alu;
  logic apb_acc;
  logic apb_hit;
  logic flags_wr;

  // Evaluate one operation against the current carry
  function automatic afl_pkg::afl_alu_t alu_eval(
    input afl_pkg::afl_req_t rq,
    input logic [4:0] fl
  );
    afl_pkg::afl_alu_t o;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bop;
    logic cin;
    o = '0;
    sum = '0;
    nib = '0;
    bop = rq.b;
    cin = 1'b0;
    case (rq.op)
      afl_pkg::OP_ADD, afl_pkg::OP_SUB: begin
        if (rq.op == afl_pkg::OP_SUB) begin
          bop = ~rq.b;  // Two's complement subtract
          cin = 1'b1;
        end
        sum = {1'b0, rq.a} + {1'b0, bop} + {8'h00, cin};
        nib = {1'b0, rq.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
        o.res = sum[7:0];
        o.flg[afl_pkg::FLG_C] = sum[8];
        o.flg[afl_pkg::FLG_DC] = nib[4];
        o.flg[afl_pkg::FLG_OV] = (rq.a[7] == bop[7]) &&
          (sum[7] != rq.a[7]);
        o.upd = 5'h1f;
      end
      afl_pkg::OP_AND: begin
        o.res = rq.a & rq.b;
        o.upd = 5'h14;
      end
      afl_pkg::OP_IOR: begin
        o.res = rq.a | rq.b;
        o.upd = 5'h14;
      end
      afl_pkg::OP_XOR: begin
        o.res = rq.a ^ rq.b;
        o.upd = 5'h14;
      end
      afl_pkg::OP_CLR: begin
        o.res = 8'h00;
        o.upd = 5'h04;  // Only zero is driven
      end
      afl_pkg::OP_BCLR: begin
        o.res = rq.a & ~(8'h01 << rq.b[2:0]);
      end
      afl_pkg::OP_BSET: begin
        o.res = rq.a | (8'h01 << rq.b[2:0]);
      end
      afl_pkg::OP_SWAP: begin
        o.res = {rq.a[3:0], rq.a[7:4]};
      end
      afl_pkg::OP_MOVE: begin
        o.res = rq.a;
      end
      afl_pkg::OP_ROTL: begin
        o.res = {rq.a[6:0], fl[afl_pkg::FLG_C]};
        o.flg[afl_pkg::FLG_C] = rq.a[7];
        o.flg[afl_pkg::FLG_DC] = rq.a[3];
        o.upd = 5'h17;
      end
      afl_pkg::OP_ROTR: begin
        o.res = {fl[afl_pkg::FLG_C], rq.a[7:1]};
        o.flg[afl_pkg::FLG_C] = rq.a[0];
        o.flg[afl_pkg::FLG_DC] = rq.a[4];
        o.upd = 5'h17;
      end
      default: begin
        o.res = rq.a;
      end
    endcase
    o.flg[afl_pkg::FLG_N] = o.res[7];
    o.flg[afl_pkg::FLG_Z] = (o.res == 8'h00);
    return o;
  endfunction

  // APB decode, zero wait states
  assign apb_acc = psel_in && penable_in;
  assign apb_hit = (paddr_in == afl_pkg::ADDR_FLAGS) ||
    (paddr_in == afl_pkg::ADDR_RESULT);
  assign flags_wr = apb_acc && pwrite_in && pstrb_in[0] &&
    (paddr_in == afl_pkg::ADDR_FLAGS);
  assign pready_out = 1'b1;
  assign pslverr_out = apb_acc && !apb_hit;

  // Read mux, upper bits read zero
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (psel_in && !pwrite_in) begin
      if (paddr_in == afl_pkg::ADDR_FLAGS) begin
        prdata_out = {27'h0, st_q.flags};
      end else if (paddr_in == afl_pkg::ADDR_RESULT) begin
        prdata_out = {24'h0, st_q.result};
      end
    end
  end

  // ALU evaluation on current flags
  assign alu = alu_eval(op_in, st_q.flags);

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    if (flags_wr) begin
      st_d.flags = pwdata_in[4:0];  // Bits 31-5 dropped
    end
    if (op_valid_in) begin
      st_d.result = alu.res;
      st_d.rvalid = 1'b1;
      if (op_in.dest_flags && alu.upd == 5'h00) begin
        st_d.flags = alu.res[4:0];  // Plain register write
      end else begin
        // Blocked write, driven flags only
        st_d.flags = (st_d.flags & ~alu.upd) | (alu.flg & alu.upd);
      end
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_q <= '{flags: afl_pkg::RST_FLAGS,
                result: afl_pkg::RST_RESULT, rvalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign result_out = st_q.result;
  assign result_valid_out = st_q.rvalid;
  assign flags_out = {3'b000, st_q.flags};

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_add_fire;
    op_valid_in && op_in.op == afl_pkg::OP_ADD;
  endsequence

  sequence s_sub_fire;
    op_valid_in && op_in.op == afl_pkg::OP_SUB;
  endsequence

  sequence s_quiet;
    !op_valid_in && !flags_wr;
  endsequence

  a_dest_block_write: assert property (
    op_valid_in && op_in.dest_flags && op_in.op == afl_pkg::OP_ADD
    |=> flags_out[4:0] == $past(alu.flg)
  ) else $error("flag write not blocked");

  a_clear_sets_z: assert property (
    op_valid_in && op_in.op == afl_pkg::OP_CLR && !flags_wr
    |=> flags_out == ({3'b000, $past(st_q.flags)} | 8'h04)
  ) else $error("clear of flags wrong");

  a_move_keeps_flags: assert property (
    op_valid_in && !op_in.dest_flags && !flags_wr &&
    op_in.op inside {afl_pkg::OP_BCLR, afl_pkg::OP_BSET,
                     afl_pkg::OP_SWAP, afl_pkg::OP_MOVE}
    |=> $stable(flags_out)
  ) else $error("move op changed flags");

  a_move_into_flags: assert property (
    op_valid_in && op_in.dest_flags && op_in.op == afl_pkg::OP_MOVE
    |=> flags_out == {3'b000, $past(op_in.a[4:0])}
  ) else $error("move into flags lost");

  a_upper_zero: assert property (
    flags_out[7:5] == 3'b000 &&
    (paddr_in != afl_pkg::ADDR_FLAGS || prdata_out[31:5] == 27'h0)
  ) else $error("upper flag bits not zero");

  a_clear_result: assert property (
    op_valid_in && op_in.op == afl_pkg::OP_CLR
    |=> result_out == 8'h00 && flags_out[afl_pkg::FLG_Z]
  ) else $error("clear result wrong");

  a_logic_keeps_carry: assert property (
    op_valid_in && !flags_wr &&
    op_in.op inside {afl_pkg::OP_AND, afl_pkg::OP_IOR, afl_pkg::OP_XOR}
    |=> (flags_out[3:0] & 4'hb) == ($past(st_q.flags[3:0]) & 4'hb)
  ) else $error("logic op changed carry flags");

  a_valid_pulse: assert property (
    !op_valid_in |=> !result_valid_out
  ) else $error("result valid without request");

  a_neg_tracks_msb: assert property (
    op_valid_in && op_in.op inside {afl_pkg::OP_ADD, afl_pkg::OP_AND}
    |=> flags_out[afl_pkg::FLG_N] == result_out[7]
  ) else $error("negative flag wrong");

  a_ovf_add: assert property (
    s_add_fire
    |=> flags_out[afl_pkg::FLG_OV] == ($past(op_in.a[7]) ==
        $past(op_in.b[7]) && result_out[7] != $past(op_in.a[7]))
  ) else $error("overflow flag wrong");

  a_zero_result: assert property (
    op_valid_in && op_in.op inside {afl_pkg::OP_XOR, afl_pkg::OP_SUB}
    |=> result_valid_out && flags_out[afl_pkg::FLG_Z] ==
        (result_out == 8'h00)
  ) else $error("zero flag wrong");

  a_nibble_carry: assert property (
    s_add_fire
    |=> flags_out[afl_pkg::FLG_DC] ==
        ($past(op_in.a[3:0]) + $past(op_in.b[3:0]) > 5'd15)
  ) else $error("nibble carry wrong");

  a_carry_add: assert property (
    s_add_fire
    |=> flags_out[afl_pkg::FLG_C] ==
        ($past(op_in.a) + $past(op_in.b) > 9'd255)
  ) else $error("carry wrong");

  a_sub_borrow: assert property (
    s_sub_fire
    |=> flags_out[afl_pkg::FLG_C] == ($past(op_in.a) >= $past(op_in.b))
        && result_out == $past(op_in.a) - $past(op_in.b)
  ) else $error("borrow wrong");

  a_rot_left: assert property (
    op_valid_in && op_in.op == afl_pkg::OP_ROTL
    |=> flags_out[afl_pkg::FLG_DC] == $past(op_in.a[3]) &&
        flags_out[afl_pkg::FLG_C] == $past(op_in.a[7])
  ) else $error("rotate left flags wrong");

  a_rot_right: assert property (
    op_valid_in && op_in.op == afl_pkg::OP_ROTR
    |=> flags_out[afl_pkg::FLG_C] == $past(op_in.a[0]) &&
        result_out[7] == $past(st_q.flags[afl_pkg::FLG_C])
  ) else $error("rotate right carry wrong");

  a_idle_hold: assert property (
    s_quiet ##1 s_quiet |=> $stable(flags_out)
  ) else $error("flags changed while idle");

endmodule

// >>> verif/afl_pipe_model.sv
/*
  Execution pipeline model: issues one ALU request at a time.
  Assumes the flag block answers within a few cycles of the request.
*/
`timescale 1ns/100ps
module afl_pipe_model (
  // Clock
  input wire logic clk_in,
  // Request to the flag block
  output logic op_valid_out,
  output afl_pkg::afl_req_t op_out,
  // Answer from the flag block
  input wire logic result_valid_in
);
  // Idle request lines
  initial begin
    op_valid_out = 1'b0;
    op_out = '0;
  end

  // One-cycle request pulse, then a bounded wait for the answer
  task automatic issue(input afl_pkg::afl_req_t r, output bit ok);
    int i;
    @(posedge clk_in);
    op_valid_out <= 1'b1;
    op_out <= r;
    @(posedge clk_in);
    op_valid_out <= 1'b0;
    op_out <= afl_pkg::afl_req_t'(~r);  // Stale operands do not linger
    ok = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_in);
      ok = (result_valid_in === 1'b1);
    end
  endtask
endmodule

// >>> verif/tb_top.sv
/*
  Self-checking bench for the ALU status flag block.
  Assumes the pipeline model and a zero-wait APB slave.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, op_valid, res_valid;
  logic [7:0] paddr, res, flags;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [4:0] efl;
  logic [7:0] eres;
  afl_pkg::afl_req_t op;
  int fail_count, checked;

  afl_status_flags afl_status_flags_i (.clk_in(clk), .resetn_in(rstn),
    .op_valid_in(op_valid), .op_in(op), .result_out(res),
    .result_valid_out(res_valid), .flags_out(flags), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  afl_pipe_model afl_pipe_model_i (.clk_in(clk), .op_valid_out(op_valid),
    .op_out(op), .result_valid_in(res_valid));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // Expected {result, flags} of one request
  function automatic logic [12:0] model(afl_pkg::afl_req_t r,
                                        logic [4:0] f);
    logic [8:0] s;
    logic [4:0] h, n, drv;
    logic [7:0] b2, y;
    logic cin;
    n = f;
    drv = 5'h13;
    y = r.a;
    cin = (r.op == afl_pkg::OP_SUB);
    b2 = cin ? ~r.b : r.b;
    s = 9'(r.a) + 9'(b2) + 9'(cin);
    h = 5'(r.a[3:0]) + 5'(b2[3:0]) + 5'(cin);
    case (r.op)
      afl_pkg::OP_ADD, afl_pkg::OP_SUB: begin
        y = s[7:0];
        n[1:0] = {h[4], s[8]};
        n[3] = (r.a[7] == b2[7]) && (y[7] != r.a[7]);
        drv = 5'h1f;
      end
      afl_pkg::OP_AND: y = r.a & r.b;
      afl_pkg::OP_IOR: y = r.a | r.b;
      afl_pkg::OP_XOR: y = r.a ^ r.b;
      afl_pkg::OP_CLR: begin
        y = 8'h00;
        drv = 5'h04;
      end
      afl_pkg::OP_BCLR: y[r.b[2:0]] = 1'b0;
      afl_pkg::OP_BSET: y[r.b[2:0]] = 1'b1;
      afl_pkg::OP_SWAP: y = {r.a[3:0], r.a[7:4]};
      afl_pkg::OP_ROTL: begin
        y = {r.a[6:0], f[0]};
        n[1:0] = {r.a[3], r.a[7]};
        drv = 5'h17;
      end
      afl_pkg::OP_ROTR: begin
        y = {f[0], r.a[7:1]};
        n[1:0] = {r.a[4], r.a[0]};
        drv = 5'h17;
      end
      default: drv = 5'h00;
    endcase
    if (drv == 5'h13)
      drv = 5'h14;
    if (r.op inside {[afl_pkg::OP_BCLR:afl_pkg::OP_MOVE]})
      drv = 5'h00;
    n[4] = y[7];
    n[2] = (y == 8'h00);
    n = (drv & n) | (~drv & f);
    if (drv == 5'h00 && r.dest_flags)
      n = y[4:0];
    return {y, n};
  endfunction

  task automatic run_op(logic [3:0] o, logic [7:0] a, b, logic d);
    afl_pkg::afl_req_t r;
    logic [12:0] p;
    bit ok;
    r = '{op: afl_pkg::afl_op_t'(o), a: a, b: b, dest_flags: d};
    p = model(r, efl);
    afl_pipe_model_i.issue(r, ok);
    if (!ok) begin
      fail_count++;
      conclude();
    end
    efl = p[4:0];
    eres = p[12:5];
    chk("result", 32'(p[12:5]), 32'(res));
    chk("flags", 32'(efl), 32'(flags));
  endtask

  // APB transfer held until pready is seen at a rising edge
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      fail_count++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    {psel, pen} <= 2'b00;
  endtask

  initial begin
    logic [31:0] q, v;
    logic e;
    int i;
    {psel, pen, pwr, paddr, pwdata, rstn} = '0;
    pstrb = 4'hf;
    fail_count = 0;
    checked = 0;
    efl = afl_pkg::RST_FLAGS;
    eres = afl_pkg::RST_RESULT;
    void'($urandom(32'h8c4bb14e));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("reset flags", 32'(efl), 32'(flags));
    // Corner cases of carry, borrow, overflow and zero
    run_op(4'h0, 8'h7f, 8'h01, 1'b0);
    run_op(4'h0, 8'hff, 8'h01, 1'b0);
    run_op(4'h1, 8'h00, 8'h01, 1'b0);
    run_op(4'h1, 8'h80, 8'h01, 1'b1);
    run_op(4'h5, 8'hff, 8'h00, 1'b1);
    run_op(4'ha, 8'h88, 8'h00, 1'b1);
    run_op(4'hb, 8'h11, 8'h00, 1'b0);
    run_op(4'h7, {3'b000, efl}, 8'h02, 1'b1);
    $display("test corner done");
    // Random requests mixed with software flag writes
    for (i = 0; i < 400; i++) begin
      v = $urandom;
      if (v[31:30] == 2'b00) begin
        apb(1'b1, afl_pkg::ADDR_FLAGS, v, q, e);
        efl = v[4:0];
      end
      run_op(4'($urandom_range(0, 11)), v[7:0], v[15:8], v[16]);
    end
    $display("test random done");
    // Register access, read-only and unmapped places
    apb(1'b1, afl_pkg::ADDR_FLAGS, 32'hffff_ffea, q, e);
    apb(1'b0, afl_pkg::ADDR_FLAGS, 32'h0, q, e);
    chk("flags read", 32'h0000_000a, q);
    apb(1'b1, afl_pkg::ADDR_RESULT, 32'h0000_005a, q, e);
    apb(1'b0, afl_pkg::ADDR_RESULT, 32'h0, q, e);
    chk("result read", 32'(eres), q);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    $display("test registers done");
    conclude();
  end
endmodule
